// [rtl/pump_seq_consts.vh]
// Constants shared by the pump sequencer control block and its test files
`ifndef PUMP_SEQ_CONSTS_VH
`define PUMP_SEQ_CONSTS_VH
// Clock rate and one-second tick
`define CLK_HZ 100000000
`define TICK_CYCLES (`CLK_HZ)
// Timing defaults, in seconds
`define DELAY_BETWEEN_S 20
`define MIN_START_S 10
`define POWER_RESUME_S 30
`define RUN_ON_DURATION_S 60
// Run-on interval default, in relay trips
`define RUN_ON_INTERVAL_TRIPS 5
// Inhibit band around the OFF setpoint, percent of span
`define OFF_BAND_PCT 5
// Relay function codes
`define FUNC_OTHER 2'h0
`define FUNC_SR_ASSIST 2'h1
`define FUNC_SR_BACKUP 2'h2
`define FUNC_COMM 2'h3
// Sensor operation codes
`define OP_SINGLE 2'h0
`define OP_DIFF 2'h1
`define OP_AVG 2'h2
// Fail-safe codes
`define FS_HOLD 2'h0
`define FS_DEENERGIZE 2'h1
`define FS_ENERGIZE 2'h2
`define FS_GLOBAL 2'h3
// Default service ratio
`define RATIO_DEFAULT 8'h01
`endif

// [rtl/sec_tick.v]
// One-second tick generator from the system clock
`timescale 1ns/100ps
`default_nettype none
module sec_tick #(
  parameter integer CYCLES = 100000000
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Tick out
  output reg tick_o
);
  reg [31:0] cnt_reg; // Cycle counter

  // Count to CYCLES and pulse once
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_reg == CYCLES - 1) begin
      cnt_reg <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule // sec_tick
`default_nettype wire

// [rtl/pump_pick.v]
// Service-ratio pump chooser: least and most weighted running hours
`timescale 1ns/100ps
`default_nettype none
module pump_pick #(
  parameter integer N = 3
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Candidates
  input wire [N-1:0] start_ok_i,
  input wire [N-1:0] stop_ok_i,
  input wire [N*32-1:0] hours_i,
  input wire [N*8-1:0] ratio_i,
  // Choices, registered
  output reg [N-1:0] start_pick_o,
  output reg [N-1:0] stop_pick_o
);
  // Cross-multiplied compare: hours_a/ratio_a < hours_b/ratio_b
  function less;
    input [31:0] ha, hb;
    input [7:0] ra, rb;
    begin
      less = ({8'h00, ha} * {32'h0000_0000, rb}) < ({8'h00, hb} * {32'h0000_0000, ra});
    end
  endfunction

  reg [N-1:0] st_n, sp_n; // One-hot next choices
  integer i, bs, bp;      // Loop and best indices

  // Linear scan; lowest index wins ties, which keeps 1:1 rotation fair
  always @* begin
    st_n = {N{1'b0}};
    sp_n = {N{1'b0}};
    bs = -1;
    bp = -1;
    for (i = 0; i < N; i = i + 1) begin
      if (start_ok_i[i] && (bs < 0 || less(hours_i[i*32 +: 32], hours_i[bs*32 +: 32],
          ratio_i[i*8 +: 8], ratio_i[bs*8 +: 8])))
        bs = i;
      if (stop_ok_i[i] && (bp < 0 || less(hours_i[bp*32 +: 32], hours_i[i*32 +: 32],
          ratio_i[bp*8 +: 8], ratio_i[i*8 +: 8])))
        bp = i;
    end
    if (bs >= 0)
      st_n[bs] = 1'b1;
    if (bp >= 0)
      sp_n[bp] = 1'b1;
  end

  // Register the picks
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      start_pick_o <= {N{1'b0}};
      stop_pick_o <= {N{1'b0}};
    end else begin
      start_pick_o <= st_n;
      stop_pick_o <= sp_n;
    end
  end
endmodule // pump_pick
`default_nettype wire

// [rtl/pump_sequencer_control.v]
// Pump sequencer: rate starts, service ratio, fail-safe, run-on, start delays
// Notes on behaviour
// (RULE1) Rate mode: start pumps until rate met
// (RULE2) Rate-mode starts spaced by between-starts delay
// (RULE3) No next start within 5% span of OFF
// (RULE4) Single point one control; dual three controls
// (RULE5) Service ratio only for service-ratio relay functions
// (RULE6) Start pump with lowest hours per ratio
// (RULE7) Stop pump with highest hours per ratio
// (RULE8) Equal ratios give equal use; default equal
// (RULE9) Other strategies override the service ratio
// (RULE10) Per-relay fail-safe overrides global fail-safe
// (RULE11) Hold mode keeps reporting last level
// (RULE12) Run-on keeps pump past OFF for duration
// (RULE13) Run-on interval counts relay trips, not cycles
// (RULE14) Minimum delay between any two starts enforced
// (RULE15) Power-resumption delay before first pump start
// (RULE16) Counters run on one-second tick, sync reset
`timescale 1ns/100ps
`default_nettype none
`include "pump_seq_consts.vh"
module pump_sequencer_control #(
  parameter integer N = 3,
  parameter integer TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Level inputs, three points, signed rate per point
  input wire [47:0] level_i,
  input wire [47:0] rate_i,
  input wire fail_i,
  // Setpoints and span, common to the pump group
  input wire [15:0] on_sp_i,
  input wire [15:0] off_sp_i,
  input wire [15:0] span_i,
  input wire pump_up_i,
  input wire [15:0] fill_ind_i,
  input wire [15:0] empty_ind_i,
  // Operation and level source
  input wire [1:0] sensor_op_i,
  input wire [1:0] level_point_i,
  input wire [2:0] rate_en_i,
  // Per-relay configuration
  input wire [N*2-1:0] relay_func_i,
  input wire [N*8-1:0] ratio_i,
  input wire [N*2-1:0] relay_fs_i,
  input wire [N*16-1:0] run_on_dur_i,
  input wire [N-1:0] comm_force_i,
  input wire [N-1:0] pump_ok_i,
  // Global settings
  input wire [1:0] fs_mode_i,
  input wire [15:0] echo_loss_timer_i,
  input wire [7:0] run_on_interval_i,
  input wire [15:0] delay_between_i,
  input wire [15:0] min_start_i,
  input wire [15:0] power_resume_i,
  // Relay drive and status
  output reg [N-1:0] relay_o,
  output reg [15:0] level_report_o,
  output reg fail_safe_o,
  output reg [N-1:0] run_on_o,
  output reg [N*32-1:0] hours_o
);
  wire tick;                   // One-second tick
  wire [N-1:0] start_pick;     // Chosen pump to start
  wire [N-1:0] stop_pick;      // Chosen pump to stop
  reg [15:0] resume_reg;       // Seconds since reset, stops at the power resume delay
  reg [15:0] since_start_reg;  // Seconds since last start
  reg [15:0] echo_reg;         // Seconds of echo loss
  reg [N-1:0] run_reg;         // Pumps running on level demand
  reg [15:0] lvl;              // Selected level
  reg signed [15:0] rate;      // Selected rate
  reg rate_ctl;                // Rate control on for selected point
  reg [N*32-1:0] sec_reg;      // Seconds inside the current hour
  reg [N*8-1:0] trips_reg;     // Trips since last run-on
  reg [N*16-1:0] ron_reg;      // Run-on seconds left
  reg [N-1:0] sr_mask;         // Relays using service ratio
  reg [N-1:0] start_ok;        // Start candidates
  reg [N-1:0] stop_ok;         // Stop candidates
  reg [N-1:0] first_free;      // Fallback when no ratio relay
  integer k;                   // Loop index

  sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  pump_pick #(.N(N)) u_pick (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_ok_i(start_ok),
    .stop_ok_i(stop_ok),
    .hours_i(hours_o),
    .ratio_i(ratio_i),
    .start_pick_o(start_pick),
    .stop_pick_o(stop_pick)
  );

  // Level point: single uses point 0, dual picks any of three
  always @* begin
    if (sensor_op_i == `OP_SINGLE) begin
      lvl = level_i[15:0]; // RULE4
      rate = rate_i[15:0];
      rate_ctl = rate_en_i[0];
    end else begin
      case (level_point_i)
        2'h1: begin
          lvl = level_i[31:16];
          rate = rate_i[31:16];
          rate_ctl = rate_en_i[1]; // RULE4
        end
        2'h2: begin
          lvl = level_i[47:32];
          rate = rate_i[47:32];
          rate_ctl = rate_en_i[2];
        end
        default: begin
          lvl = level_i[15:0];
          rate = rate_i[15:0];
          rate_ctl = rate_en_i[0];
        end
      endcase
    end
  end

  // Demand terms
  wire on_reached = pump_up_i ? (lvl <= on_sp_i) : (lvl >= on_sp_i);
  wire off_reached = pump_up_i ? (lvl >= off_sp_i) : (lvl <= off_sp_i);
  wire [31:0] band = ({16'h0000, span_i} * `OFF_BAND_PCT) / 100;
  wire [15:0] diff = (lvl > off_sp_i) ? lvl - off_sp_i : off_sp_i - lvl;
  wire near_off = ({16'h0000, diff} <= band); // RULE3
  // Rate magnitude toward the target direction
  wire rate_met = pump_up_i ? (rate >= $signed({1'b0, fill_ind_i[14:0]}))
                            : (-rate >= $signed({1'b0, empty_ind_i[14:0]})); // RULE1
  wire resumed = (resume_reg >= power_resume_i); // RULE15
  wire spaced = (since_start_reg >= min_start_i) &&
                (!rate_ctl || since_start_reg >= delay_between_i); // RULE2 RULE14
  wire free_any = |(~run_reg & pump_ok_i & ~comm_force_i);
  // Rate mode: keep adding pumps until rate met; else start on ON setpoint
  wire want_start = rate_ctl ? ((on_reached || |run_reg) && !rate_met && !near_off)
                             : (on_reached && !near_off); // RULE1 RULE3
  wire do_start = want_start && resumed && spaced && free_any && !fail_i;
  wire do_stop = off_reached && |run_reg;

  // Candidate masks; other strategies take over when no ratio relay applies
  always @* begin
    first_free = {N{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      sr_mask[k] = (relay_func_i[k*2 +: 2] == `FUNC_SR_ASSIST) ||
                   (relay_func_i[k*2 +: 2] == `FUNC_SR_BACKUP); // RULE5
      start_ok[k] = sr_mask[k] && !run_reg[k] && pump_ok_i[k] && !comm_force_i[k]; // RULE9
      stop_ok[k] = sr_mask[k] && run_reg[k];
      if (!run_reg[k] && pump_ok_i[k] && !comm_force_i[k] && !sr_mask[k])
        first_free = {N{1'b0}} | ({{(N-1){1'b0}}, 1'b1} << k);
    end
  end

  // Global timers, all on the one-second tick
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      resume_reg <= 16'h0000;
      since_start_reg <= 16'hffff;
      echo_reg <= 16'h0000;
    end else begin
      if (tick && !resumed)
        resume_reg <= resume_reg + 16'h0001; // RULE16
      if (do_start)
        since_start_reg <= 16'h0000;
      else if (tick && since_start_reg != 16'hffff)
        since_start_reg <= since_start_reg + 16'h0001; // RULE16
      if (!fail_i)
        echo_reg <= 16'h0000;
      else if (tick && echo_reg != 16'hffff)
        echo_reg <= echo_reg + 16'h0001;
    end
  end

  wire fs_active = fail_i && (echo_reg >= echo_loss_timer_i); // Fail-safe after timer

  // Level report: hold keeps last value in fail-safe
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      level_report_o <= 16'h0000;
      fail_safe_o <= 1'b0;
    end else begin
      fail_safe_o <= fs_active;
      if (!(fs_active && fs_mode_i == `FS_HOLD))
        level_report_o <= lvl; // RULE11
    end
  end

  // Pump run state: one start or one stop per cycle; a non-ratio stop drops every non-ratio pump at once
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      run_reg <= {N{1'b0}};
    end else if (do_stop) begin
      // Stop picks most hours per ratio; non-ratio pumps stop together
      run_reg <= (|stop_ok) ? (run_reg & ~stop_pick) : (run_reg & sr_mask); // RULE7
    end else if (do_start) begin
      run_reg <= run_reg | ((|start_ok) ? start_pick : first_free); // RULE6 RULE8
    end
  end

  // Per-relay hours, trips and run-on
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_relay
      wire stopping = run_reg[g] && do_stop &&
                      ((|stop_ok) ? stop_pick[g] : !sr_mask[g]);
      always @(posedge clk_sys_i) begin
        if (reset_i) begin
          sec_reg[g*32 +: 32] <= 32'h0000_0000;
          hours_o[g*32 +: 32] <= 32'h0000_0000;
          trips_reg[g*8 +: 8] <= 8'h00;
          ron_reg[g*16 +: 16] <= 16'h0000;
        end else begin
          // Running hours, whole hours only
          if (tick && relay_o[g]) begin
            if (sec_reg[g*32 +: 32] == 32'd3599) begin
              sec_reg[g*32 +: 32] <= 32'h0000_0000;
              hours_o[g*32 +: 32] <= hours_o[g*32 +: 32] + 32'h0000_0001;
            end else begin
              sec_reg[g*32 +: 32] <= sec_reg[g*32 +: 32] + 32'h0000_0001;
            end
          end
          // Each trip of this relay counts toward run-on interval
          if (stopping) begin
            if (trips_reg[g*8 +: 8] + 8'h01 >= run_on_interval_i &&
                run_on_dur_i[g*16 +: 16] != 16'h0000) begin
              trips_reg[g*8 +: 8] <= 8'h00; // RULE13
              ron_reg[g*16 +: 16] <= run_on_dur_i[g*16 +: 16]; // RULE12
            end else begin
              trips_reg[g*8 +: 8] <= trips_reg[g*8 +: 8] + 8'h01; // RULE13
            end
          end else if (tick && ron_reg[g*16 +: 16] != 16'h0000) begin
            ron_reg[g*16 +: 16] <= ron_reg[g*16 +: 16] - 16'h0001; // RULE16
          end
        end
      end
    end
  endgenerate

  // Relay drive with fail-safe override per relay
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      relay_o <= {N{1'b0}};
      run_on_o <= {N{1'b0}};
    end else begin
      for (k = 0; k < N; k = k + 1) begin
        run_on_o[k] <= (ron_reg[k*16 +: 16] != 16'h0000);
        if (relay_func_i[k*2 +: 2] == `FUNC_COMM)
          relay_o[k] <= comm_force_i[k];
        else if (fs_active && relay_fs_i[k*2 +: 2] != `FS_GLOBAL) begin
          // Per-relay setting wins over the global one
          relay_o[k] <= (relay_fs_i[k*2 +: 2] == `FS_ENERGIZE) ? 1'b1 :
                        (relay_fs_i[k*2 +: 2] == `FS_DEENERGIZE) ? 1'b0 : relay_o[k]; // RULE10
        end else if (fs_active) begin
          relay_o[k] <= (fs_mode_i == `FS_ENERGIZE) ? 1'b1 :
                        (fs_mode_i == `FS_DEENERGIZE) ? 1'b0 : relay_o[k];
        end else
          relay_o[k] <= run_reg[k] || (ron_reg[k*16 +: 16] != 16'h0000); // RULE12
      end
    end
  end
endmodule // pump_sequencer_control
`default_nettype wire

// [test/pump_plant.sv]
// Level front end model: rate follows the number of running pumps
`timescale 1ns/100ps
`default_nettype none
module pump_plant (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Level from bench, relays from block
  input wire logic [15:0] level_set_i,
  input wire logic [2:0] relay_i,
  // Three-point level and signed rate
  output logic [47:0] level_o,
  output logic [47:0] rate_o
);
  // Signed rate, one cycle of lag
  logic [15:0] rate_reg;
  // Inflow 100, each pump drains 150: two pumps are needed for a net drain of 150 or more
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rate_reg <= 16'h0000;
    end else begin
      rate_reg <= 16'h0064 - 16'h0096 * (relay_i[0] + relay_i[1] + relay_i[2]);
    end
  end
  // Same level and rate on all three points
  assign level_o = {3{level_set_i}};
  assign rate_o = {3{rate_reg}};
endmodule // pump_plant
`default_nettype wire

// [test/pump_sequencer_control_asserts.sv]
// Checker for the pump sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "pump_seq_consts.vh"
module pump_sequencer_control_asserts #(
  parameter integer N = 3,
  parameter integer TICK_CYCLES = 10
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Watched inputs
  input wire [47:0] level_i,
  input wire [15:0] off_sp_i,
  input wire [15:0] span_i,
  input wire [1:0] sensor_op_i,
  input wire [2:0] rate_en_i,
  input wire [N*2-1:0] relay_func_i,
  input wire [N*2-1:0] relay_fs_i,
  input wire [N*16-1:0] run_on_dur_i,
  input wire [1:0] fs_mode_i,
  input wire [15:0] delay_between_i,
  input wire [15:0] min_start_i,
  input wire [15:0] power_resume_i,
  // Watched outputs
  input wire [N-1:0] relay_o,
  input wire [15:0] level_report_o,
  input wire fail_safe_o,
  input wire [N-1:0] run_on_o
);
  // Helper state: previous relays, recent fail-safe, delayed level
  logic [N-1:0] prev_relay, comm_mask, rise;
  logic [1:0] fs_d;
  logic [15:0] lvl_d1, lvl_d2, diff, band;
  logic [31:0] gap, up;
  integer k;
  // Comm relays may jump freely, so they are left out of start checks
  always @* begin
    for (k = 0; k < N; k = k + 1) begin
      comm_mask[k] = relay_func_i[2*k +: 2] == `FUNC_COMM;
    end
  end
  // Fail-safe may energize several relays at once; no start counted then
  assign rise = (fail_safe_o || |fs_d) ? '0 : relay_o & ~prev_relay & ~comm_mask;
  assign diff = lvl_d2 >= off_sp_i ? lvl_d2 - off_sp_i : off_sp_i - lvl_d2;
  assign band = 16'((32'(span_i) * 5) / 100);
  // Gap since last start and cycles since reset, both saturating
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      prev_relay <= '0;
      fs_d <= 2'h0;
      gap <= '1;
      up <= 32'h0000_0000;
    end else begin
      prev_relay <= relay_o;
      fs_d <= {fs_d[0], fail_safe_o};
      gap <= |rise ? 32'h0000_0001 : (&gap ? gap : gap + 32'h0000_0001);
      up <= &up ? up : up + 32'h0000_0001;
    end
    lvl_d1 <= level_i[15:0];
    lvl_d2 <= lvl_d1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_reset_zero;
    $fell(reset_i) |-> relay_o == '0 && run_on_o == '0 && !fail_safe_o && level_report_o == 0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear at reset");
  property p_one_start;
    $countones(rise) <= 1;
  endproperty
  a_one_start: assert property (p_one_start) else $error("two pumps started at once");
  property p_min_gap;
    |rise |-> gap >= (min_start_i - 1) * TICK_CYCLES;
  endproperty
  a_min_gap: assert property (p_min_gap) else $error("starts too close");
  property p_rate_gap;
    |rise && rate_en_i[0] && sensor_op_i == `OP_SINGLE |-> gap >= (delay_between_i - 1) * TICK_CYCLES;
  endproperty
  a_rate_gap: assert property (p_rate_gap) else $error("rate starts too close");
  property p_power;
    |rise |-> up >= (power_resume_i - 1) * TICK_CYCLES;
  endproperty
  a_power: assert property (p_power) else $error("start before power resume delay");
  property p_off_band;
    |rise && prev_relay != '0 && rate_en_i[0] && sensor_op_i == `OP_SINGLE |-> diff >= band;
  endproperty
  a_off_band: assert property (p_off_band) else $error("start near off setpoint");
  property p_hold;
    fail_safe_o && $past(fail_safe_o) && fs_mode_i == `FS_HOLD |-> $stable(level_report_o);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved in hold");
  property p_relay_fs;
    fail_safe_o && $past(fail_safe_o, 2) |-> (relay_fs_i[3:2] != `FS_ENERGIZE || relay_o[1])
      && (relay_fs_i[5:4] != `FS_DEENERGIZE || !relay_o[2]);
  endproperty
  a_relay_fs: assert property (p_relay_fs) else $error("relay fail-safe ignored");
  property p_run_on_hold;
    !fail_safe_o && fs_d == 2'h0 |-> (run_on_o & $past(run_on_o) & ~relay_o) == '0;
  endproperty
  a_run_on_hold: assert property (p_run_on_hold) else $error("relay dropped in run-on");
  property p_run_on_len;
    $rose(run_on_o[0]) && run_on_dur_i[15:1] != 0 && !fail_safe_o |-> run_on_o[0] [*8];
  endproperty
  a_run_on_len: assert property (p_run_on_len) else $error("run-on too short");
  c_two: cover property (relay_o == 3'b011);
  c_run_on: cover property ($rose(run_on_o[0]));
  c_fail: cover property ($rose(fail_safe_o));
endmodule // pump_sequencer_control_asserts
bind pump_sequencer_control pump_sequencer_control_asserts #(.N(N), .TICK_CYCLES(TICK_CYCLES))
  asserts_i (.clk_sys_i, .reset_i, .level_i, .off_sp_i, .span_i, .sensor_op_i, .rate_en_i,
  .relay_func_i, .relay_fs_i, .run_on_dur_i, .fs_mode_i, .delay_between_i, .min_start_i,
  .power_resume_i, .relay_o, .level_report_o, .fail_safe_o, .run_on_o);
`default_nettype wire

// [test/pump_sequencer_control_tb.sv]
// Testbench for the pump sequencer: starts, stops, run-on, fail-safe
`timescale 1ns/100ps
`default_nettype none
`include "pump_seq_consts.vh"
module pump_sequencer_control_tb;
  // Clock, reset and control inputs
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic fail_i = 1'b0;
  logic pump_up_i = 1'b0;
  logic [15:0] level_set = 16'h0900;
  logic [15:0] on_sp_i = 16'h0800, off_sp_i = 16'h0200, span_i = 16'h1000;
  logic [15:0] fill_ind_i = 16'h0096, empty_ind_i = 16'h0096, echo_loss_timer_i = 16'h0001;
  logic [15:0] delay_between_i = 16'h0003, min_start_i = 16'h0002, power_resume_i = 16'h0003;
  logic [1:0] sensor_op_i = `OP_SINGLE, level_point_i = 2'h0, fs_mode_i = `FS_HOLD;
  logic [2:0] rate_en_i = 3'b001, comm_force_i = 3'h0, pump_ok_i = 3'h7;
  // All three relays on service ratio assist, ratio 1:2:1
  logic [5:0] relay_func_i = 6'h15, relay_fs_i = 6'h3f;
  logic [23:0] ratio_i = 24'h01_0201;
  logic [47:0] run_on_dur_i = 48'h0000_0000_0002;
  logic [7:0] run_on_interval_i = 8'h01;
  // Plant and block outputs
  wire [47:0] level_i, rate_i;
  wire [2:0] relay_o, run_on_o;
  wire [15:0] level_report_o;
  wire fail_safe_o;
  wire [95:0] hours_o; // Whole running hours, three relays
  int n_errors = 0, check_count = 0, cycles = 0;
  pump_plant pump_plant_i (.clk_sys_i, .reset_i, .level_set_i(level_set), .relay_i(relay_o),
    .level_o(level_i), .rate_o(rate_i));
  // Short tick keeps second-based delays to tens of cycles
  pump_sequencer_control #(.N(3), .TICK_CYCLES(10)) pump_sequencer_control_i (.clk_sys_i,
    .reset_i, .level_i, .rate_i, .fail_i, .on_sp_i, .off_sp_i, .span_i, .pump_up_i, .fill_ind_i,
    .empty_ind_i, .sensor_op_i, .level_point_i, .rate_en_i, .relay_func_i, .ratio_i, .relay_fs_i,
    .run_on_dur_i, .comm_force_i, .pump_ok_i, .fs_mode_i, .echo_loss_timer_i, .run_on_interval_i,
    .delay_between_i, .min_start_i, .power_resume_i, .relay_o, .level_report_o, .fail_safe_o,
    .run_on_o, .hours_o);
  // Clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move on falling edges only
  task tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Bounded wait for a relay pattern, then compare
  task wait_relay(input logic [2:0] exp, input int limit);
    for (int k = 0; k < limit && relay_o !== exp; k++) @(negedge clk_sys_i);
    check(relay_o, exp);
  endtask
  // Reset then first start after the power resume delay
  task power_resume_start;
    reset_i = 1'b1;
    tick(5);
    reset_i = 1'b0;
    tick(15);
    check(relay_o, 3'b000);
    wait_relay(3'b001, 100);
  endtask
  // Rate mode adds one pump; two meet the emptying rate
  task rate_starts;
    wait_relay(3'b011, 200);
    tick(100);
    check(relay_o, 3'b011);
  endtask
  // OFF reached: stops, relay 0 runs on alone
  task stop_run_on;
    level_set = 16'h0100;
    wait_relay(3'b001, 10);
    check(run_on_o, 3'b001);
    wait_relay(3'b000, 40);
    check(run_on_o, 3'b000);
  endtask
  // Second reset mid-run; level near OFF blocks the next pump
  task off_band;
    level_set = 16'h0900;
    power_resume_start();
    level_set = 16'h0250;
    tick(100);
    check(relay_o, 3'b001);
  endtask
  // Echo loss under global hold with relay overrides
  task fail_safe_hold;
    relay_fs_i = {`FS_DEENERGIZE, `FS_ENERGIZE, `FS_GLOBAL};
    check(level_report_o, 16'h0250);
    fail_i = 1'b1;
    for (int k = 0; k < 40 && fail_safe_o !== 1'b1; k++) @(negedge clk_sys_i);
    check(fail_safe_o, 1'b1);
    level_set = 16'h0700;
    tick(3);
    check(level_report_o, 16'h0250);
    check(relay_o, 3'b011);
    // No pump has run a full hour in this short run
    check({15'h0000, |hours_o}, 16'h0000);
    // Comm relay follows its forced state even in fail-safe
    relay_fs_i = 6'h3f;
    relay_func_i[5:4] = `FUNC_COMM;
    comm_force_i = 3'b100;
    tick(3);
    check(relay_o, 3'b111);
  endtask
  // Counts, verdict, end of run
  task wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    power_resume_start();
    rate_starts();
    stop_run_on();
    off_band();
    fail_safe_hold();
    wrap_up();
  end
endmodule // pump_sequencer_control_tb
`default_nettype wire
